/* File: verilog/frrc_map.svh */
// Command codes, field codes, reset values and timing for fault response
`ifndef FRRC_MAP_SVH
`define FRRC_MAP_SVH
`define FRRC_CMD_COLD_ACT 8'h54
`define FRRC_CMD_TRIP 8'h55
`define FRRC_CMD_HIGH_ACT 8'h56
`define FRRC_RESP_DR 2'h2
`define FRRC_COUNT_NONE 3'h0
`define FRRC_COUNT_FOREVER 3'h7
`define FRRC_ACT_RST 8'h80
`define FRRC_TRIP_RST 16'hffff
`define FRRC_RETRY_STEP_MS 35
`define FRRC_CLK_KHZ 25000
`define FRRC_STEP_CYC (`FRRC_RETRY_STEP_MS * `FRRC_CLK_KHZ)
`endif

/* File: verilog/frrc_pkg.sv */
// Types shared by the fault response and retry control block
package frrc_pkg;
   typedef struct packed {
      logic [1:0] resp;
      logic [2:0] count;
      logic [2:0] rtime;
   } frrc_action_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic word;
      logic [7:0] code;
      logic [15:0] wdata;
   } frrc_req_t;
   typedef struct packed {
      logic valid;
      logic err;
      logic [15:0] rdata;
   } frrc_rsp_t;
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_WAIT,
      SEQ_LATCH
   } frrc_seq_state_t;
endpackage

/* File: verilog/frrc_sync3.sv */
// Three flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module frrc_sync3 (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Pin in, filtered level out
   input wire logic d,
   output logic q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Change taken only once stages two and three agree
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         q <= 1'b0;
      end else if (s2_q == s3_q) begin
         q <= s3_q;
      end
   end
endmodule

/* File: verilog/frrc_retry_seq.sv */
// Shutdown and retry sequencer for one fault source
`timescale 1ns/1ps
`include "frrc_map.svh"
module frrc_retry_seq #(
   parameter int STEP_CYC = `FRRC_STEP_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Settings and fault
   input frrc_pkg::frrc_action_t action,
   input wire logic fault,
   input wire logic run_en,
   input wire logic clear,
   input wire logic other_off,
   // State
   output frrc_pkg::frrc_seq_state_t state_q,
   output logic off
);
   logic [31:0] cyc_q;
   logic [2:0] steps_q;
   logic [2:0] tries_q;
   logic step_end;
   logic step_done;
   logic may_retry;

   assign step_end = (cyc_q == 32'(STEP_CYC - 1));
   assign step_done = step_end && (steps_q == action.rtime);
   assign may_retry = (action.count == `FRRC_COUNT_FOREVER) ||
      (tries_q < action.count);
   assign off = (state_q != frrc_pkg::SEQ_IDLE);

   // Delay divider runs only while waiting, so each wait is exact
   always_ff @(posedge clk_sys) begin
      if (srst || state_q != frrc_pkg::SEQ_WAIT) begin
         cyc_q <= '0;
         steps_q <= '0;
      end else if (step_end) begin
         cyc_q <= '0;
         steps_q <= steps_q + 3'h1;
      end else begin
         cyc_q <= cyc_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_q <= frrc_pkg::SEQ_IDLE;
         tries_q <= '0;
      end else begin
         unique case (state_q)
            frrc_pkg::SEQ_IDLE: begin
               // Other response codes only flag, never shut down
               if (run_en && fault && action.resp == `FRRC_RESP_DR) begin
                  if (may_retry) begin
                     state_q <= frrc_pkg::SEQ_WAIT;
                     if (action.count != `FRRC_COUNT_FOREVER) begin
                        tries_q <= tries_q + 3'h1;
                     end
                  end else begin
                     state_q <= frrc_pkg::SEQ_LATCH;
                  end
               end else if (clear || !run_en) begin
                  tries_q <= '0;
               end
            end
            frrc_pkg::SEQ_WAIT: begin
               if (!run_en) begin
                  state_q <= frrc_pkg::SEQ_IDLE;
                  tries_q <= '0;
               end else if (other_off) begin
                  state_q <= frrc_pkg::SEQ_LATCH;
               end else if (step_done) begin
                  state_q <= frrc_pkg::SEQ_IDLE;
               end
            end
            frrc_pkg::SEQ_LATCH: begin
               if (clear && !fault) begin
                  state_q <= frrc_pkg::SEQ_IDLE;
                  tries_q <= '0;
               end
            end
         endcase
      end
   end
endmodule

/* File: verilog/frrc_ctrl.sv */
// Fault response registers, over-voltage compare, alert and output gating
// Function
// - Any fault sets its status bit and pulls the alert line low.
// - Disable-and-retry code turns output off at once, then retries.
// - Number of restart attempts equals the three-bit retry count field.
// - Retry count zero keeps output off until the fault is cleared.
// - Retry count seven retries forever until disabled or another fault.
// - Retry spacing is retry time field plus one, times 35 ms.
// - Byte at command 0x54 sets the under-temperature fault response.
// - Sixteen-bit threshold at 0x55; input above it is an over-voltage fault.
// - Byte at command 0x56 sets the input over-voltage fault response.
// - Threshold is read and written with word transfers only.
// - Both response registers are read and written with byte transfers.
`timescale 1ns/1ps
`include "frrc_map.svh"
module frrc_ctrl #(
   parameter int STEP_CYC = `FRRC_STEP_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Command port from the management bus engine
   input frrc_pkg::frrc_req_t cmd_req,
   output frrc_pkg::frrc_rsp_t cmd_rsp,
   // Sensing
   input wire logic cold_fault_pin,
   input wire logic [15:0] vin_sample,
   input wire logic vin_sample_valid,
   // Control
   input wire logic output_enable_pin,
   input wire logic status_clear,
   // Alert line, open drain
   output logic alert_line_o,
   output logic alert_line_oe,
   // Status and power stage
   output logic output_on,
   output logic status_cold_fault,
   output logic status_input_high_fault
);
   frrc_pkg::frrc_action_t cold_act_q;
   frrc_pkg::frrc_action_t high_act_q;
   logic [15:0] trip_q;
   logic cold_lvl;
   logic run_en;
   logic cold_prev_q;
   logic vin_high_q;
   logic vin_high_prev_q;
   logic cold_event;
   logic high_event;
   logic cold_off;
   logic high_off;
   frrc_pkg::frrc_seq_state_t cold_st;
   frrc_pkg::frrc_seq_state_t high_st;
   logic legal_d;
   logic [15:0] rd_d;
   logic wr_ok;

   // Pin inputs
   frrc_sync3 u_sync_cold (
      .clk_sys(clk_sys),
      .srst(srst),
      .d(cold_fault_pin),
      .q(cold_lvl)
   );

   frrc_sync3 u_sync_en (
      .clk_sys(clk_sys),
      .srst(srst),
      .d(output_enable_pin),
      .q(run_en)
   );

   // Command decode: only the documented transfer size is accepted
   always_comb begin
      legal_d = 1'b0;
      rd_d = '0;
      case (cmd_req.code)
         `FRRC_CMD_COLD_ACT: begin
            legal_d = !cmd_req.word;
            rd_d = {8'h00, cold_act_q};
         end
         `FRRC_CMD_TRIP: begin
            legal_d = cmd_req.word;
            rd_d = trip_q;
         end
         `FRRC_CMD_HIGH_ACT: begin
            legal_d = !cmd_req.word;
            rd_d = {8'h00, high_act_q};
         end
         default: begin
            legal_d = 1'b0;
            rd_d = '0;
         end
      endcase
   end

   assign wr_ok = cmd_req.valid && cmd_req.write && legal_d;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cold_act_q <= frrc_pkg::frrc_action_t'(`FRRC_ACT_RST);
         high_act_q <= frrc_pkg::frrc_action_t'(`FRRC_ACT_RST);
         trip_q <= `FRRC_TRIP_RST;
      end else if (wr_ok) begin
         case (cmd_req.code)
            `FRRC_CMD_COLD_ACT: begin
               cold_act_q <= frrc_pkg::frrc_action_t'(cmd_req.wdata[7:0]);
            end
            `FRRC_CMD_TRIP: begin
               trip_q <= cmd_req.wdata;
            end
            `FRRC_CMD_HIGH_ACT: begin
               high_act_q <= frrc_pkg::frrc_action_t'(cmd_req.wdata[7:0]);
            end
            default: begin
               trip_q <= trip_q;
            end
         endcase
      end
   end

   // Answer one cycle after every request; bad size or code flagged
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cmd_rsp <= '0;
      end else begin
         cmd_rsp.valid <= cmd_req.valid;
         cmd_rsp.err <= cmd_req.valid && !legal_d;
         if (cmd_req.valid && !cmd_req.write && legal_d) begin
            cmd_rsp.rdata <= rd_d;
         end else begin
            cmd_rsp.rdata <= '0;
         end
      end
   end

   // Raw compare; sample held until the next valid one
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         vin_high_q <= 1'b0;
      end else if (vin_sample_valid) begin
         vin_high_q <= (vin_sample > trip_q);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cold_prev_q <= 1'b0;
         vin_high_prev_q <= 1'b0;
      end else begin
         cold_prev_q <= cold_lvl;
         vin_high_prev_q <= vin_high_q;
      end
   end

   assign cold_event = cold_lvl && !cold_prev_q;
   assign high_event = vin_high_q && !vin_high_prev_q;

   // Set beats clear so a fault in the clear cycle is kept
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         status_cold_fault <= 1'b0;
         status_input_high_fault <= 1'b0;
      end else begin
         status_cold_fault <= cold_event ||
            (status_cold_fault && !status_clear);
         status_input_high_fault <= high_event ||
            (status_input_high_fault && !status_clear);
      end
   end

   // Alert pulled low for every response mode while a bit stands
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         alert_line_o <= 1'b0;
         alert_line_oe <= 1'b0;
      end else begin
         alert_line_o <= 1'b0;
         alert_line_oe <= status_cold_fault || status_input_high_fault;
      end
   end

   frrc_retry_seq #(
      .STEP_CYC(STEP_CYC)
   ) u_seq_cold (
      .clk_sys(clk_sys),
      .srst(srst),
      .action(cold_act_q),
      .fault(cold_lvl),
      .run_en(run_en),
      .clear(status_clear),
      .other_off(high_off),
      .state_q(cold_st),
      .off(cold_off)
   );

   frrc_retry_seq #(
      .STEP_CYC(STEP_CYC)
   ) u_seq_high (
      .clk_sys(clk_sys),
      .srst(srst),
      .action(high_act_q),
      .fault(vin_high_q),
      .run_en(run_en),
      .clear(status_clear),
      .other_off(cold_off),
      .state_q(high_st),
      .off(high_off)
   );

   // Either source holds the stage off; costs one cycle of latency
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         output_on <= 1'b0;
      end else begin
         output_on <= run_en && !cold_off && !high_off;
      end
   end

   // Helper: cycles spent in the current cold wait
   logic [31:0] wait_cnt_q;
   logic [31:0] wait_lim;
   assign wait_lim = (32'(cold_act_q.rtime) + 32'h0000_0001) *
      32'(STEP_CYC) - 32'h0000_0001;

   always_ff @(posedge clk_sys) begin
      if (srst || cold_st != frrc_pkg::SEQ_WAIT) begin
         wait_cnt_q <= '0;
      end else begin
         wait_cnt_q <= wait_cnt_q + 32'h0000_0001;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   property p_alert_follows_status;
      (status_cold_fault || status_input_high_fault) |=> alert_line_oe;
   endproperty
   a_alert_follows_status: assert property (p_alert_follows_status)
      else $error("alert not pulled low while status bit set");

   property p_cold_status_set;
      cold_event |=> status_cold_fault [*2];
   endproperty
   a_cold_status_set: assert property (p_cold_status_set)
      else $error("cold fault did not set and hold status");

   property p_high_status_set;
      high_event |=> status_input_high_fault;
   endproperty
   a_high_status_set: assert property (p_high_status_set)
      else $error("over-voltage event did not set status");

   property p_dr_off_at_once;
      (cold_st == frrc_pkg::SEQ_IDLE && run_en && cold_lvl &&
         cold_act_q.resp == `FRRC_RESP_DR) |-> ##2 !output_on;
   endproperty
   a_dr_off_at_once: assert property (p_dr_off_at_once)
      else $error("output not off two cycles after fault");

   property p_no_retry_holds;
      (cold_st == frrc_pkg::SEQ_LATCH && !status_clear) |=>
         cold_st == frrc_pkg::SEQ_LATCH && !output_on;
   endproperty
   a_no_retry_holds: assert property (p_no_retry_holds)
      else $error("latched source left off state without clear");

   property p_forever_no_latch;
      (cold_st == frrc_pkg::SEQ_WAIT && run_en && !high_off &&
         cold_act_q.count == `FRRC_COUNT_FOREVER) |=>
         cold_st != frrc_pkg::SEQ_LATCH;
   endproperty
   a_forever_no_latch: assert property (p_forever_no_latch)
      else $error("continuous retry gave up");

   property p_wait_length;
      (cold_st == frrc_pkg::SEQ_WAIT && run_en && !high_off) |=>
         ((cold_st == frrc_pkg::SEQ_IDLE) ==
          ($past(wait_cnt_q) == $past(wait_lim)));
   endproperty
   a_wait_length: assert property (p_wait_length)
      else $error("retry delay length wrong");

   property p_trip_compare;
      (vin_sample_valid && vin_sample > trip_q) |=> vin_high_q;
   endproperty
   a_trip_compare: assert property (p_trip_compare)
      else $error("input above threshold not flagged");

   property p_trip_word_write;
      (cmd_req.valid && cmd_req.write && cmd_req.word &&
         cmd_req.code == `FRRC_CMD_TRIP) |=>
         trip_q == $past(cmd_req.wdata) && cmd_rsp.valid && !cmd_rsp.err;
   endproperty
   a_trip_word_write: assert property (p_trip_word_write)
      else $error("threshold word write not taken");

   property p_byte_read;
      (cmd_req.valid && !cmd_req.write && !cmd_req.word &&
         cmd_req.code == `FRRC_CMD_COLD_ACT) |=>
         cmd_rsp.valid && cmd_rsp.rdata == {8'h00, $past(cold_act_q)};
   endproperty
   a_byte_read: assert property (p_byte_read)
      else $error("response byte read returned wrong data");

   property p_flag_only_mode;
      (cold_st == frrc_pkg::SEQ_IDLE &&
         cold_act_q.resp != `FRRC_RESP_DR) |=>
         cold_st == frrc_pkg::SEQ_IDLE;
   endproperty
   a_flag_only_mode: assert property (p_flag_only_mode)
      else $error("non retry response shut the output");
endmodule

/* File: tb/frrc_host.sv */
// Host model driving the command port of the fault response block
`timescale 1ns/1ps
module frrc_host (
   // Clock
   input wire logic clk_sys,
   // Command port
   output frrc_pkg::frrc_req_t cmd_req,
   input frrc_pkg::frrc_rsp_t cmd_rsp
);
   initial begin
      cmd_req = '0;
   end
   // One request, answer read just after the edge that takes the strobe
   task automatic xfer(input logic wr, input logic wd, input logic [7:0] c,
      input logic [15:0] w, output frrc_pkg::frrc_rsp_t rsp);
      @(posedge clk_sys);
      cmd_req <= '{1'b1, wr, wd, c, w};
      @(posedge clk_sys);
      // Idle data is scrambled so a stale value never looks valid
      cmd_req <= '{1'b0, ~wr, ~wd, ~c, ~w};
      // Answer is launched by this edge and stands one cycle only
      #1;
      rsp = cmd_rsp;
   endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the fault response and retry block
`timescale 1ns/1ps
`define CHK(a, e) chk(32'(a), 32'(e))
module tb;
   localparam int S = 20;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   frrc_pkg::frrc_req_t cmd_req;
   frrc_pkg::frrc_rsp_t cmd_rsp;
   frrc_pkg::frrc_rsp_t rsp;
   logic cold_fault_pin = 1'b0;
   logic [15:0] vin_sample = 16'h0000;
   logic vin_sample_valid = 1'b0;
   logic output_enable_pin = 1'b1;
   logic status_clear = 1'b0;
   logic alert_line_o, alert_line_oe, output_on, st_cold, st_high;
   logic [15:0] m [3] = '{16'h0080, 16'hffff, 16'h0080};
   logic [15:0] w;
   logic [7:0] c;
   logic [2:0] rt;
   logic wd, wr, e;
   int fail_count = 0;
   int samples_checked = 0;
   int n, i, k, j;
   always #20 clk_sys = ~clk_sys;
   frrc_ctrl #(.STEP_CYC(S)) dut (.clk_sys(clk_sys), .srst(srst),
      .cmd_req(cmd_req), .cmd_rsp(cmd_rsp), .cold_fault_pin(cold_fault_pin),
      .vin_sample(vin_sample), .vin_sample_valid(vin_sample_valid),
      .output_enable_pin(output_enable_pin), .status_clear(status_clear),
      .alert_line_o(alert_line_o), .alert_line_oe(alert_line_oe),
      .output_on(output_on), .status_cold_fault(st_cold),
      .status_input_high_fault(st_high));
   frrc_host host (.clk_sys(clk_sys), .cmd_req(cmd_req), .cmd_rsp(cmd_rsp));
   function automatic logic bad(logic [7:0] cc, logic ww);
      return (cc == 8'h55) ? !ww : (cc == 8'h54 || cc == 8'h56) ? ww : 1'b1;
   endfunction
   function automatic int off_len(logic [2:0] t);
      return (int'(t) + 1) * S;
   endfunction
   task automatic chk(input logic [31:0] a, input logic [31:0] x);
      samples_checked++;
      if (a !== x) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, a, x);
      end
   endtask
   task automatic test_done;
      $display("checked=%0d failed=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Bounded wait on the power stage enable
   task automatic wait_out(input logic v, output int cnt);
      cnt = 0;
      while (output_on !== v) begin
         @(posedge clk_sys);
         #1;
         cnt++;
         if (cnt > 3000) begin
            `CHK(output_on, v);
            test_done;
         end
      end
   endtask
   task automatic wreg(input logic [7:0] cc, input logic [15:0] ww);
      host.xfer(1'b1, cc == 8'h55, cc, ww, rsp);
   endtask
   task automatic clear;
      @(posedge clk_sys);
      status_clear <= 1'b1;
      @(posedge clk_sys);
      status_clear <= 1'b0;
   endtask
   task automatic ov(input logic [15:0] v);
      @(posedge clk_sys);
      vin_sample <= v;
      vin_sample_valid <= 1'b1;
      @(posedge clk_sys);
      vin_sample <= ~v;
      vin_sample_valid <= 1'b0;
   endtask
   task automatic cold(input logic v);
      @(posedge clk_sys);
      cold_fault_pin <= v;
   endtask
   initial begin
      void'($urandom(18));
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      for (k = 0; k < 3; k++) begin
         host.xfer(1'b0, k == 1, 8'h54 + 8'(k), 16'h0000, rsp);
         `CHK(rsp.rdata, m[k]);
      end
      // Random sizes and codes, neighbours of the map among them
      for (i = 0; i < 30; i++) begin
         c = 8'h53 + 8'($urandom_range(4));
         wd = 1'($urandom_range(1));
         wr = 1'($urandom_range(1));
         w = 16'($urandom);
         host.xfer(wr, wd, c, w, rsp);
         e = bad(c, wd);
         `CHK({rsp.valid, rsp.err}, {1'b1, e});
         if (e || wr) `CHK(rsp.rdata, 16'h0000);
         else `CHK(rsp.rdata, m[c - 8'h54]);
         if (wr && !e) m[c - 8'h54] = wd ? w : {8'h00, w[7:0]};
      end
      wreg(8'h54, 16'h0080);
      wreg(8'h56, 16'h0000);
      wreg(8'h55, 16'h1000);
      // Cold fault, no retry: latched off until cleared
      cold(1'b1);
      wait_out(1'b0, n);
      `CHK(n <= 8, 1);
      `CHK({st_cold, alert_line_oe, alert_line_o}, 3'b110);
      repeat (3 * S) @(posedge clk_sys);
      cold(1'b0);
      repeat (6) @(posedge clk_sys);
      `CHK(output_on, 1'b0);
      clear;
      wait_out(1'b1, n);
      `CHK({st_cold, alert_line_oe}, 2'b00);
      // Threshold is strict, flag-only response keeps the output on
      ov(16'h1000);
      repeat (3) @(posedge clk_sys);
      `CHK(st_high, 1'b0);
      ov(16'h1001);
      repeat (3) @(posedge clk_sys);
      `CHK({st_high, alert_line_oe, output_on}, 3'b111);
      ov(16'h0000);
      clear;
      repeat (2) @(posedge clk_sys);
      // Two retries, third fault latches; spacing per retry time
      for (j = 0; j < 2; j++) begin
         rt = j ? 3'h7 : 3'($urandom_range(6));
         wreg(8'h56, {8'h00, 2'b10, 3'h2, rt});
         for (k = 0; k < 3; k++) begin
            ov(16'hf000);
            wait_out(1'b0, n);
            `CHK(n <= 4, 1);
            ov(16'h0000);
            if (k < 2) begin
               wait_out(1'b1, n);
               `CHK(n >= off_len(rt) - 4 && n <= off_len(rt) + 2, 1);
            end
         end
         repeat (9 * S) @(posedge clk_sys);
         `CHK(output_on, 1'b0);
         clear;
         wait_out(1'b1, n);
      end
      // Unlimited retries outlast any finite count
      wreg(8'h54, 16'h00b8);
      for (k = 0; k < 9; k++) begin
         cold(1'b1);
         wait_out(1'b0, n);
         cold(1'b0);
         wait_out(1'b1, n);
         `CHK(n <= off_len(3'h0) + 6, 1);
      end
      @(posedge clk_sys);
      output_enable_pin <= 1'b0;
      wait_out(1'b0, n);
      `CHK(n <= 8, 1);
      test_done;
   end
endmodule
